/* hdl/two_wire_diag_write_slave.sv */
// two-wire target write path into the diagnostic space
//
// Contract
// RQ1: only writes addressed to the diagnostic space may change memory.
// RQ2: SDA falling while SCL high starts a transfer.
// RQ3: address byte A0 selects identification space, A2 diagnostic space.
// RQ4: each accepted byte is acknowledged by one low bit on SDA.
// RQ5: writable offsets are 6E and 80 through F7.
// RQ6: address, then start offset, then data byte, each acknowledged.
// RQ7: further data bytes go to consecutive offsets.
// RQ8: SDA rising while SCL high ends the transfer.
// RQ9: no start is served until 250 ms after power-up.
// RQ10: each space holds 256 bytes at eight-bit offsets.
// RQ11: bytes for non-writable offsets are dropped yet acknowledged.
`timescale 1ns/100ps
module two_wire_diag_write_slave
  import diag_write_pkg::*;
#(
  parameter int POWERUP_CYCLES = POWERUP_CYCLES_DEF
)(
  input wire logic i_clk_sys, // system clock, 40 MHz
  input wire logic i_nrst, // async reset, active low
  input wire logic i_scl, // bus clock level
  input wire logic i_sda, // bus data level
  output logic o_sda_out, // data drive value, always low
  output logic o_sda_oe_n, // low while driving SDA
  input wire logic i_mem_hold, // stalls memory writes
  input wire logic [7:0] i_rd_offset, // local read offset
  output logic [7:0] o_rd_data, // diagnostic byte at read offset
  output logic o_link_ready, // power-up time has passed
  output logic o_busy, // transfer in progress
  output logic o_wr_strobe, // pulse: memory byte written
  output logic [7:0] o_wr_offset, // offset of written byte
  output logic [7:0] o_wr_data // value of written byte
);

  logic scl_q;
  logic sda_q;
  logic scl_p;
  logic sda_p;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic [PWR_CNT_W-1:0] pwr_cnt;
  xfer_state_t state;
  xfer_state_t next_state;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic [7:0] offset;
  logic space_diag;
  logic receiving;
  logic in_ack;
  logic byte_done;
  logic addr_ok;
  logic data_ok;
  logic ack_now;
  logic push_now;
  logic buf_in_ready;
  logic buf_out_valid;
  logic buf_out_ready;
  logic [BUF_WIDTH-1:0] buf_out_data;
  logic drain;
  logic [7:0] diag_mem [SPACE_BYTES];

  // bus level sampling and condition detection
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end
    else
    begin
      scl_q <= i_scl;
      sda_q <= i_sda;
      scl_p <= scl_q;
      sda_p <= sda_q;
    end
  end

  assign scl_rise = scl_q && !scl_p;
  assign scl_fall = !scl_q && scl_p;
  assign start_cond = scl_q && scl_p && sda_p && !sda_q; // see RQ2
  assign stop_cond = scl_q && scl_p && !sda_p && sda_q; // see RQ8

  // power-up wait before starts are honoured
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      pwr_cnt <= '0;
      o_link_ready <= 1'b0;
    end
    else if (!o_link_ready)
    begin
      if (pwr_cnt == PWR_CNT_W'(POWERUP_CYCLES - 1)) // see RQ9
      begin
        o_link_ready <= 1'b1;
      end
      else
      begin
        pwr_cnt <= pwr_cnt + 1'b1;
      end
    end
  end

  assign receiving = (state == ST_ADDR) || (state == ST_OFFS) || (state == ST_DATA);
  assign in_ack = (state == ST_ACK_ADDR) || (state == ST_ACK_OFFS) || (state == ST_ACK_DATA);
  assign byte_done = receiving && scl_fall && (bit_cnt == BYTE_BITS);
  assign addr_ok = (shift == DEV_ADDR_ID) || (shift == DEV_ADDR_DIAG); // see RQ3
  assign data_ok = space_diag && offset_writable(offset); // see RQ1 RQ5

  // a full buffer refuses a good byte; a dropped byte is still taken
  always_comb
  begin
    ack_now = 1'b0;
    case (state)
      ST_ADDR: ack_now = byte_done && addr_ok;
      ST_OFFS: ack_now = byte_done; // see RQ6
      ST_DATA: ack_now = byte_done && (!data_ok || buf_in_ready); // see RQ11
      default: ack_now = 1'b0;
    endcase
  end

  assign push_now = byte_done && (state == ST_DATA) && data_ok && buf_in_ready; // see RQ1

  always_comb
  begin
    next_state = state;
    if (start_cond && o_link_ready) // see RQ2 RQ9
    begin
      next_state = ST_ADDR;
    end
    else if (stop_cond) // see RQ8
    begin
      next_state = ST_IDLE;
    end
    else
    begin
      case (state)
        ST_ADDR: if (byte_done) next_state = ack_now ? ST_ACK_ADDR : ST_WAIT;
        ST_ACK_ADDR: if (scl_fall) next_state = ST_OFFS;
        ST_OFFS: if (byte_done) next_state = ST_ACK_OFFS;
        ST_ACK_OFFS: if (scl_fall) next_state = ST_DATA;
        ST_DATA: if (byte_done) next_state = ack_now ? ST_ACK_DATA : ST_WAIT;
        ST_ACK_DATA: if (scl_fall) next_state = ST_DATA; // see RQ7
        default: next_state = state;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state <= ST_IDLE;
      o_busy <= 1'b0;
    end
    else
    begin
      state <= next_state;
      o_busy <= (next_state != ST_IDLE);
    end
  end

  // bit reception, sampled on the rising bus clock
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      bit_cnt <= '0;
      shift <= '0;
    end
    else if (start_cond || stop_cond || (in_ack && scl_fall))
    begin
      bit_cnt <= '0;
    end
    else if (receiving && scl_rise && (bit_cnt != BYTE_BITS))
    begin
      bit_cnt <= bit_cnt + 1'b1;
      shift <= {shift[6:0], sda_q};
    end
  end

  // selected space and running offset
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      space_diag <= 1'b0;
      offset <= OFFSET_RST;
    end
    else if (byte_done)
    begin
      case (state)
        ST_ADDR: space_diag <= (shift == DEV_ADDR_DIAG); // see RQ3
        ST_OFFS: offset <= shift; // see RQ6
        ST_DATA: offset <= offset + 1'b1; // see RQ7 RQ10
        default: offset <= offset;
      endcase
    end
  end

  // acknowledge drive from the fall after bit eight to the next fall
  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_sda_oe_n <= 1'b1;
      o_sda_out <= 1'b0;
    end
    else
    begin
      o_sda_out <= 1'b0;
      if (start_cond || stop_cond)
      begin
        o_sda_oe_n <= 1'b1;
      end
      else if (ack_now)
      begin
        o_sda_oe_n <= 1'b0; // see RQ4
      end
      else if (in_ack && scl_fall)
      begin
        o_sda_oe_n <= 1'b1;
      end
    end
  end

  two_entry_buffer #(
    .WIDTH(BUF_WIDTH),
    .DEPTH(BUF_DEPTH)
  ) u_wr_buf (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_in_valid(push_now),
    .o_in_ready(buf_in_ready),
    .i_in_data({offset, shift}),
    .o_out_valid(buf_out_valid),
    .i_out_ready(buf_out_ready),
    .o_out_data(buf_out_data)
  );

  assign buf_out_ready = !i_mem_hold;
  assign drain = buf_out_valid && buf_out_ready;

  // diagnostic space storage
  always_ff @(posedge i_clk_sys)
  begin
    if (drain)
    begin
      diag_mem[buf_out_data[15:8]] <= buf_out_data[7:0]; // see RQ10
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_wr_strobe <= 1'b0;
      o_wr_offset <= OFFSET_RST;
      o_wr_data <= RD_DATA_RST;
      o_rd_data <= RD_DATA_RST;
    end
    else
    begin
      o_wr_strobe <= drain;
      o_rd_data <= diag_mem[i_rd_offset];
      if (drain)
      begin
        o_wr_offset <= buf_out_data[15:8];
        o_wr_data <= buf_out_data[7:0];
      end
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);

  AST_NO_ID_WRITE: assert property (push_now |-> space_diag) // see RQ1
    else $error("write pushed outside the diagnostic space");
  AST_START_ADDR: assert property (start_cond && o_link_ready |=> state == ST_ADDR) // see RQ2
    else $error("start not taken");
  AST_ADDR_ACK: assert property (
    byte_done && state == ST_ADDR && shift == DEV_ADDR_DIAG |=> !o_sda_oe_n) // see RQ3
    else $error("diagnostic address not acknowledged");
  AST_ACK_HOLD: assert property (
    !o_sda_oe_n && !scl_fall && !start_cond && !stop_cond |=> !o_sda_oe_n) // see RQ4
    else $error("acknowledge released early");
  AST_WRITABLE: assert property (push_now |-> offset_writable(offset)) // see RQ5
    else $error("byte pushed at a protected offset");
  AST_PUSH_ACK: assert property (push_now |=> !o_sda_oe_n ##1 !o_sda_oe_n) // see RQ6
    else $error("stored byte not acknowledged");
  AST_OFFS_INC: assert property (
    byte_done && state == ST_DATA |=> offset == $past(offset) + 8'h01) // see RQ7
    else $error("offset did not advance");
  AST_STOP_IDLE: assert property (stop_cond && !start_cond |=> state == ST_IDLE && !o_busy) // see RQ8
    else $error("stop did not end transfer");
  AST_NOT_READY: assert property (!o_link_ready |-> state == ST_IDLE) // see RQ9
    else $error("transfer before power-up time");
  AST_MEM_WRITE: assert property (
    drain |=> diag_mem[$past(buf_out_data[15:8])] == $past(buf_out_data[7:0])) // see RQ10
    else $error("memory byte not stored");
  AST_BAD_OFFS_ACK: assert property (
    byte_done && state == ST_DATA && !data_ok |=> !o_sda_oe_n ##1 !o_wr_strobe) // see RQ11
    else $error("dropped byte not acknowledged");

  COV_STORE: cover property (push_now ##[1:400] drain);
  COV_MULTI: cover property (push_now ##[1:800] push_now);
  COV_FULL_NACK: cover property (byte_done && state == ST_DATA && data_ok && !buf_in_ready);
  COV_ID_DROP: cover property (byte_done && state == ST_DATA && !space_diag);

endmodule // two_wire_diag_write_slave

/* hdl/diag_write_pkg.sv */
// constants and types shared by the two-wire diagnostic write target
package diag_write_pkg;

  // device address bytes, direction bit low for a write
  localparam logic [7:0] DEV_ADDR_ID = 8'hA0;
  localparam logic [7:0] DEV_ADDR_DIAG = 8'hA2;

  // writable offsets of the diagnostic space
  localparam logic [7:0] OFFS_SINGLE = 8'h6E;
  localparam logic [7:0] OFFS_LO = 8'h80;
  localparam logic [7:0] OFFS_HI = 8'hF7;

  // each space holds this many bytes
  localparam int SPACE_BYTES = 256;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // reset values
  localparam logic [7:0] OFFSET_RST = 8'h00;
  localparam logic [7:0] RD_DATA_RST = 8'h00;

  // power-up time before the bus is served
  localparam int POWERUP_MS = 250;
  localparam int SYS_CLK_HZ = 40_000_000;
  localparam int POWERUP_CYCLES_DEF = POWERUP_MS * (SYS_CLK_HZ / 1000);
  localparam int PWR_CNT_W = 24;

  // buffer word: offset in the high byte, data in the low byte
  localparam int BUF_WIDTH = 16;
  localparam int BUF_DEPTH = 2;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ACK_ADDR,
    ST_OFFS,
    ST_ACK_OFFS,
    ST_DATA,
    ST_ACK_DATA,
    ST_WAIT
  } xfer_state_t;

  function automatic logic offset_writable(input logic [7:0] offs);
    offset_writable = (offs == OFFS_SINGLE) || ((offs >= OFFS_LO) && (offs <= OFFS_HI));
  endfunction

endpackage

/* hdl/two_entry_buffer.sv */
// small valid/ready buffer between the bus side and the memory write side
`timescale 1ns/100ps
module two_entry_buffer #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
)(
  input wire logic i_clk_sys, // system clock
  input wire logic i_nrst, // async reset, active low
  input wire logic i_in_valid, // word offered
  output logic o_in_ready, // room for a word
  input wire logic [WIDTH-1:0] i_in_data, // word in
  output logic o_out_valid, // word available
  input wire logic i_out_ready, // drain side takes word
  output logic [WIDTH-1:0] o_out_data // oldest word
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] slot [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign o_in_ready = (count != (AW+1)'(DEPTH));
  assign o_out_valid = (count != '0);
  assign o_out_data = slot[rd_ptr];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_ff @(posedge i_clk_sys)
  begin
    if (push)
    begin
      slot[wr_ptr] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop)
      begin
        count <= count + 1'b1;
      end
      else if (pop && !push)
      begin
        count <= count - 1'b1;
      end
    end
  end

endmodule // two_entry_buffer

/* verif/two_wire_host_model.sv */
// behavioural two-wire bus master with an open-drain data line
`timescale 1ns/100ps
module two_wire_host_model (
  input wire logic i_clk_sys, // bench clock, used for pacing only
  input wire logic i_sda, // resolved data line level
  output logic o_scl, // bus clock, high when idle
  output logic o_sda // 0 pulls data low, 1 releases it
);
  int hp = 4; // clocks per bus phase, raised to answer slowly
  initial
  begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic ph();
    repeat (hp) @(posedge i_clk_sys);
    #1;
  endtask
  // also gives a repeated start when the clock is low
  task automatic start();
    o_sda = 1'b1;
    ph();
    o_scl = 1'b1;
    ph();
    o_sda = 1'b0;
    ph();
    o_scl = 1'b0;
    ph();
  endtask
  task automatic stop();
    o_sda = 1'b0;
    ph();
    o_scl = 1'b1;
    ph();
    o_sda = 1'b1;
    ph();
  endtask
  // data changes only while the clock is low, msb first
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      o_sda = b[i];
      ph();
      o_scl = 1'b1;
      ph();
      o_scl = 1'b0;
      ph();
    end
    o_sda = 1'b1;
    ph();
    o_scl = 1'b1;
    ph();
    ack = !i_sda;
    ph();
    o_scl = 1'b0;
    ph();
  endtask
endmodule // two_wire_host_model

/* verif/test_two_wire_diag_write_slave.sv */
// self-checking bench for the diagnostic write target
`timescale 1ns/100ps
module test_two_wire_diag_write_slave;
  import diag_write_pkg::*;
  localparam int PWR = 16;
  logic i_clk_sys = 1'b0;
  logic i_nrst = 1'b0;
  logic i_mem_hold = 1'b0;
  logic [7:0] i_rd_offset = 8'h00;
  logic scl;
  logic m_sda;
  logic sda_line;
  logic o_sda_out;
  logic o_sda_oe_n;
  logic [7:0] o_rd_data;
  logic o_link_ready;
  logic o_busy;
  logic o_wr_strobe;
  logic [7:0] o_wr_offset;
  logic [7:0] o_wr_data;
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int mem[256];
  logic [15:0] exp_q[$];
  logic [7:0] devs[5] = '{8'hA0, 8'hA1, 8'hA3, 8'h22, 8'hA4};

  always #12.5 i_clk_sys = ~i_clk_sys;
  // pull-up on the data line, either party may pull it low
  assign sda_line = o_sda_oe_n ? m_sda : (o_sda_out & m_sda);

  two_wire_host_model host (
    .i_clk_sys(i_clk_sys),
    .i_sda(sda_line),
    .o_scl(scl),
    .o_sda(m_sda)
  );

  two_wire_diag_write_slave #(.POWERUP_CYCLES(PWR)) uut (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_scl(scl),
    .i_sda(sda_line),
    .o_sda_out(o_sda_out),
    .o_sda_oe_n(o_sda_oe_n),
    .i_mem_hold(i_mem_hold),
    .i_rd_offset(i_rd_offset),
    .o_rd_data(o_rd_data),
    .o_link_ready(o_link_ready),
    .o_busy(o_busy),
    .o_wr_strobe(o_wr_strobe),
    .o_wr_offset(o_wr_offset),
    .o_wr_data(o_wr_data)
  );

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask

  // one transfer of n data bytes; without fin the next start is a repeated one
  task automatic xfer(input logic [7:0] dev, input logic [7:0] offs, input int n, input bit fin);
    logic ack;
    logic rdy;
    logic [7:0] o;
    logic [7:0] d;
    bit ok;
    bit full;
    int pend;
    pend = 0;
    rdy = o_link_ready;
    host.start();
    check(16'(o_busy), 16'(rdy));
    host.send_byte(dev, ack);
    check(16'(ack), 16'(rdy && (dev == DEV_ADDR_ID || dev == DEV_ADDR_DIAG)));
    if (ack === 1'b1)
    begin
      host.send_byte(offs, ack);
      check(16'(ack), 16'h0001);
      for (int k = 0; k < n; k++)
      begin
        o = offs + 8'(k);
        d = 8'($urandom);
        ok = dev == DEV_ADDR_DIAG && (o == OFFS_SINGLE || (o >= OFFS_LO && o <= OFFS_HI));
        full = ok && i_mem_hold && pend == 2;
        // queue the expected write first: unless i_mem_hold is set, the strobe comes before send_byte returns
        if (ok && !full)
        begin
          exp_q.push_back({o, d});
          mem[o] = int'(d);
          pend += int'(i_mem_hold);
        end
        host.send_byte(d, ack);
        check(16'(ack), 16'(!full));
        if (ack !== 1'b1)
          break;
      end
    end
    if (fin)
    begin
      host.stop();
      tick(4);
      check(16'(o_busy), 16'h0000);
    end
  endtask

  // every memory write must match the next expected one
  always @(negedge i_clk_sys)
    if (o_wr_strobe === 1'b1)
      check({o_wr_offset, o_wr_data}, exp_q.size() > 0 ? exp_q.pop_front() : 16'hFFFF);

  always @(posedge i_clk_sys)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_errors++;
      close_out();
    end
  end

  initial
  begin
    foreach (mem[i])
      mem[i] = -1;
    void'($urandom(8));
    tick(20);
    i_nrst = 1'b1;
    check(16'(o_link_ready), 16'h0000);
    xfer(DEV_ADDR_DIAG, 8'h80, 1, 1'b1);
    check(16'(o_link_ready), 16'h0001);
    foreach (devs[i])
      xfer(devs[i], 8'h80, 1, 1'b1);
    xfer(DEV_ADDR_DIAG, 8'h6D, 3, 1'b1);
    xfer(DEV_ADDR_DIAG, 8'hF5, 5, 1'b1);
    xfer(DEV_ADDR_DIAG, 8'h7F, 3, 1'b1);
    xfer(DEV_ADDR_DIAG, 8'hFF, 2, 1'b1);
    host.hp = 9;
    xfer(DEV_ADDR_DIAG, 8'hA0, 2, 1'b0);
    host.hp = 4;
    xfer(DEV_ADDR_DIAG, 8'hB0, 2, 1'b1);
    i_mem_hold = 1'b1;
    xfer(DEV_ADDR_DIAG, 8'hC0, 3, 1'b1);
    tick(10);
    i_mem_hold = 1'b0;
    repeat (3)
      xfer(DEV_ADDR_DIAG, 8'($urandom), $urandom_range(1, 4), 1'b1);
    tick(10);
    check(16'(exp_q.size()), 16'h0000);
    for (int a = 0; a < 256; a++)
      if (mem[a] >= 0)
      begin
        i_rd_offset = 8'(a);
        tick(2);
        check(16'(o_rd_data), 16'(mem[a]));
      end
    close_out();
  end
endmodule // test_two_wire_diag_write_slave
